// ==== stm_master.sv ====
// Line master for a single-wire thermometer: slots, bytes, search, pullup
module stm_master (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_valid_i,           // Request offered
    input wire stm_pkg::stm_req_type req_i, // Request contents
    output logic req_ready_o,               // Request taken this cycle
    output logic rsp_valid_o,               // One-cycle answer pulse
    output stm_pkg::stm_rsp_type rsp_o,     // Answer contents
    output logic [7:0] crc_o,               // Running CRC of read bytes
    output logic line_o,                    // Line drive value
    output logic line_oe_o,                 // Line driven while high
    input wire logic line_i,                // Line level from the pin
    output logic pullup_o                   // Strong pullup active
);

    typedef enum {ST_IDLE, ST_RST, ST_BITS, ST_PULL} stm_st_type;

    stm_st_type st_q;                       // Main sequencer state
    stm_pkg::stm_req_type req_q;            // Request being served
    stm_pkg::stm_rsp_type rsp_q;            // Answer registers
    logic rsp_vld_q;                        // Answer pulse register
    logic [7:0] sh_q;                       // Byte shifter
    logic [2:0] idx_q;                      // Bit index in the byte
    logic [1:0] step_q;                     // Search step
    logic [7:0] crc_q;                      // CRC accumulator
    logic [stm_pkg::TMR_W-1:0] pu_q;        // Pullup countdown
    logic sync1_q;                          // First synchroniser stage
    logic sync2_q;                          // Second synchroniser stage
    logic slot_start;                       // Launch a slot
    logic [1:0] slot_kind;                  // Kind of slot to launch
    logic slot_bit;                         // Bit for a write slot
    logic slot_oe;                          // Slot pulls line low
    logic slot_bit_in;                      // Bit the slot sampled
    logic slot_done;                        // Slot finished
    logic last_bit;                         // Final bit of the byte
    logic [stm_pkg::TMR_W-1:0] pu_len;      // Pullup length of request
    logic busy_q; // Slot in flight
    logic pu_op; // Request asks for the strong pullup
    stm_st_type take_st; // Phase that a taken request enters

    // Fold one bit into the CRC, low bit first
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = (c >> 1) ^ (fb ? stm_pkg::CRC_POLY_REFL : 8'h00);
    endfunction

    // Two-stage synchroniser on the pin
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= line_i;
            sync2_q <= sync1_q;
        end
    end

    // Slot engine
    stm_slot u_slot (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .start_i(slot_start),
        .kind_i(slot_kind),
        .bit_i(slot_bit),
        .line_i(sync2_q),
        .line_oe_o(slot_oe),
        .bit_o(slot_bit_in),
        .done_o(slot_done)
    );

    // Request decode
    assign req_ready_o = (st_q == ST_IDLE);
    assign last_bit = (idx_q == 3'd7);
    assign pu_len = (req_i.op == stm_pkg::STM_OP_PULLUP_CONV) ?
        stm_pkg::TMR_W'(stm_pkg::CONV_PU_CYC) :
        stm_pkg::TMR_W'(stm_pkg::COPY_PU_CYC);
    // Search: two read slots then one write of the chosen bit
    assign slot_kind = (st_q == ST_RST) ? 2'd2 :
        (req_q.op == stm_pkg::STM_OP_READ_BYTE) ? 2'd1 :
        (req_q.op == stm_pkg::STM_OP_SEARCH_BIT && step_q != 2'd2) ? 2'd1
        : 2'd0;
    // Write bit: shifter low bit, or search direction
    assign slot_bit = (req_q.op == stm_pkg::STM_OP_SEARCH_BIT) ?
        req_q.dir_bit : sh_q[0];
    // A new slot starts only once the previous one has ended
    assign slot_start = (st_q == ST_RST || st_q == ST_BITS) && !busy_q;
    assign pu_op = (req_i.op == stm_pkg::STM_OP_PULLUP_COPY) ||
        (req_i.op == stm_pkg::STM_OP_PULLUP_CONV);
    // Taken request picks its phase: reset, pullup or bit slots
    assign take_st = (req_i.op == stm_pkg::STM_OP_RESET) ? ST_RST :
        (pu_op ? ST_PULL : ST_BITS);

    // Pullup drives the line high; slots pull it low
    assign pullup_o = (st_q == ST_PULL);
    assign line_oe_o = slot_oe || pullup_o;
    assign line_o = pullup_o;
    assign rsp_valid_o = rsp_vld_q;
    assign rsp_o = rsp_q;
    assign crc_o = crc_q;

    // Main sequencer
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q <= ST_IDLE;
            req_q <= '0;
            rsp_q <= '0;
            rsp_vld_q <= 1'b0;
            sh_q <= 8'h00;
            idx_q <= 3'd0;
            step_q <= 2'd0;
            crc_q <= 8'h00;
            pu_q <= '0;
            busy_q <= 1'b0;
        end else begin
            rsp_vld_q <= 1'b0;
            if (slot_start) begin
                busy_q <= 1'b1;
            end else if (slot_done) begin
                busy_q <= 1'b0;
            end
            case (st_q)
                ST_IDLE: begin
                    idx_q <= 3'd0;
                    step_q <= 2'd0;
                    if (req_valid_i) begin
                        req_q <= req_i;
                        // Match code and identity go out as plain bytes
                        sh_q <= req_i.data;
                        pu_q <= pu_len;
                        st_q <= take_st;
                    end
                end
                ST_RST: begin
                    // Any reset abandons a pending pad transfer
                    if (slot_done) begin
                        rsp_q.presence <= slot_bit_in;
                        crc_q <= 8'h00;
                        rsp_vld_q <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                ST_BITS: begin
                    if (slot_done) begin
                        if (req_q.op == stm_pkg::STM_OP_SEARCH_BIT) begin
                            step_q <= step_q + 2'd1;
                            if (step_q == 2'd0) begin
                                rsp_q.id_bit <= slot_bit_in;
                            end else if (step_q == 2'd1) begin
                                rsp_q.cmp_bit <= slot_bit_in;
                            end else begin
                                rsp_q.dir_taken <= req_q.dir_bit;
                                rsp_vld_q <= 1'b1;
                                st_q <= ST_IDLE;
                            end
                        end else begin
                            // Bits leave and arrive low first
                            sh_q <= {slot_bit_in, sh_q[7:1]};
                            idx_q <= idx_q + 3'd1;
                            if (req_q.op == stm_pkg::STM_OP_READ_BYTE) begin
                                crc_q <= crc_step(crc_q, slot_bit_in);
                            end
                            if (last_bit) begin
                                rsp_q.data <= {slot_bit_in, sh_q[7:1]};
                                rsp_vld_q <= 1'b1;
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_PULL: begin
                    // No slot may start while the pullup holds
                    pu_q <= pu_q - 1'b1;
                    if (pu_q == stm_pkg::TMR_W'(1)) begin
                        rsp_vld_q <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Strong pullup never overlaps a bit slot
    a_pull_no_slot: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) pullup_o |-> !slot_oe)
        else $error("slot during strong pullup");

    // Copy pullup lasts at least its least time
    a_copy_pull_len: assert property (@(posedge clk_i)
        disable iff (!rst_b_i)
        $rose(pullup_o) |-> pu_q >= stm_pkg::TMR_W'(stm_pkg::COPY_PU_CYC))
        else $error("pullup shorter than copy time");

    // Convert pullup lasts the full conversion time
    a_conv_pull_len: assert property (@(posedge clk_i)
        disable iff (!rst_b_i)
        $rose(pullup_o) && req_q.op == stm_pkg::STM_OP_PULLUP_CONV
        |-> pu_q == stm_pkg::TMR_W'(stm_pkg::CONV_PU_CYC))
        else $error("pullup shorter than conversion time");

    // Line is handed back to the resistor after the pullup
    a_pull_ends_idle: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) $fell(pullup_o) |-> !line_oe_o)
        else $error("line still driven after pullup");

    // Idle master leaves the line released
    a_idle_line_free: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) st_q == ST_IDLE |-> !line_oe_o)
        else $error("line driven while idle");

    // Every slot begins with the line pulled low
    a_slot_opens_low: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) slot_start |=> line_oe_o && !line_o)
        else $error("slot did not open low");

endmodule

// ==== stm_pkg.sv ====
// Package with timing, command codes and request types for the line master
package stm_pkg;

    // Clock rate in kHz
    localparam int unsigned CLK_KHZ = 20000;

    // Documented times in microseconds or milliseconds
    localparam int unsigned RESET_LOW_TIME_US = 480;
    localparam int unsigned RESET_HIGH_TIME_US = 480;
    localparam int unsigned PRESENCE_SAMPLE_US = 70;
    localparam int unsigned SLOT_TIME_US = 70;
    localparam int unsigned WRITE1_LOW_US = 6;
    localparam int unsigned WRITE0_LOW_US = 60;
    localparam int unsigned READ_LOW_US = 2;
    localparam int unsigned READ_SAMPLE_US = 12;
    localparam int unsigned RECOVERY_US = 5;
    localparam int unsigned COPY_PULLUP_MS = 10;
    localparam int unsigned CONVERT_PULLUP_MS = 750;

    // Cycle counts derived from the clock rate (least times round up)
    localparam int unsigned RST_LOW_CYC =
        (RESET_LOW_TIME_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned RST_HIGH_CYC =
        (RESET_HIGH_TIME_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned PRES_SMP_CYC =
        (PRESENCE_SAMPLE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned SLOT_CYC =
        (SLOT_TIME_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned W1_LOW_CYC =
        (WRITE1_LOW_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned W0_LOW_CYC =
        (WRITE0_LOW_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned RD_LOW_CYC =
        (READ_LOW_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned RD_SMP_CYC =
        (READ_SAMPLE_US * CLK_KHZ) / 1000;
    localparam int unsigned REC_CYC =
        (RECOVERY_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned COPY_PU_CYC = COPY_PULLUP_MS * CLK_KHZ;
    localparam int unsigned CONV_PU_CYC = CONVERT_PULLUP_MS * CLK_KHZ;

    // Width of the slot timer
    localparam int unsigned TMR_W = 24;

    // Command codes of the far device
    localparam logic [7:0] CMD_READ_ID = 8'h33;
    localparam logic [7:0] CMD_MATCH = 8'h55;
    localparam logic [7:0] CMD_SKIP = 8'hcc;
    localparam logic [7:0] CMD_SEARCH = 8'hf0;
    localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;
    localparam logic [7:0] CMD_WRITE_PAD = 8'h4e;
    localparam logic [7:0] CMD_READ_PAD = 8'hbe;
    localparam logic [7:0] CMD_COPY = 8'h48;
    localparam logic [7:0] CMD_CONVERT = 8'h44;
    localparam logic [7:0] CMD_RECALL = 8'hb8;

    // Scratchpad layout of the far device
    localparam int unsigned PAD_BYTES = 9;
    localparam int unsigned PAD_UPPER_IDX = 2;
    localparam int unsigned PAD_LOWER_IDX = 3;
    localparam logic [7:0] CRC_POLY_REFL = 8'h8c;

    // Operations a user may request
    typedef enum logic [2:0] {
        STM_OP_RESET,
        STM_OP_WRITE_BYTE,
        STM_OP_READ_BYTE,
        STM_OP_SEARCH_BIT,
        STM_OP_PULLUP_COPY,
        STM_OP_PULLUP_CONV
    } stm_op_type;

    // Request from the user side
    typedef struct packed {
        stm_op_type op;
        logic [7:0] data;
        logic dir_bit;
    } stm_req_type;

    // Answer to the user side
    typedef struct packed {
        logic [7:0] data;
        logic presence;
        logic id_bit;
        logic cmp_bit;
        logic dir_taken;
    } stm_rsp_type;

endpackage

// ==== stm_slot.sv ====
// One bit slot or reset pulse on the single data line
module stm_slot (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,           // One-cycle start of a slot
    input wire logic [1:0] kind_i,      // 0 write, 1 read, 2 reset
    input wire logic bit_i,             // Bit to write
    input wire logic line_i,            // Synchronised line level
    output logic line_oe_o,             // Pulls the line low while high
    output logic bit_o,                 // Sampled bit or presence
    output logic done_o                 // One-cycle end of the slot
);

    localparam logic [1:0] K_WR = 2'd0;
    localparam logic [1:0] K_RD = 2'd1;

    typedef enum {SL_IDLE, SL_LOW, SL_HIGH} stm_sl_type;

    stm_sl_type st_q;                   // Slot phase
    logic [stm_pkg::TMR_W-1:0] cnt_q;   // Cycles into the phase
    logic [1:0] kind_q;                 // Kind of the running slot
    logic bit_q;                        // Bit being written
    logic smp_q;                        // Sampled value
    logic [stm_pkg::TMR_W-1:0] low_len; // Length of the low phase
    logic [stm_pkg::TMR_W-1:0] tot_len; // Length of the high phase, timed from the release
    logic [stm_pkg::TMR_W-1:0] smp_at;  // Sample point

    // Phase lengths per kind
    assign low_len = (kind_q == K_RD) ? stm_pkg::TMR_W'(stm_pkg::RD_LOW_CYC) :
        (kind_q == K_WR) ? (bit_q ? stm_pkg::TMR_W'(stm_pkg::W1_LOW_CYC)
        : stm_pkg::TMR_W'(stm_pkg::W0_LOW_CYC))
        : stm_pkg::TMR_W'(stm_pkg::RST_LOW_CYC);
    assign tot_len = (kind_q[1]) ? stm_pkg::TMR_W'(stm_pkg::RST_HIGH_CYC)
        : stm_pkg::TMR_W'(stm_pkg::SLOT_CYC + stm_pkg::REC_CYC);
    assign smp_at = (kind_q[1]) ? stm_pkg::TMR_W'(stm_pkg::PRES_SMP_CYC)
        : stm_pkg::TMR_W'(stm_pkg::RD_SMP_CYC);

    // Every slot opens with the line pulled low
    assign line_oe_o = (st_q == SL_LOW);
    assign bit_o = smp_q;
    assign done_o = (st_q == SL_HIGH) && (cnt_q == tot_len - 1'b1);

    // Slot sequencer
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q <= SL_IDLE;
            cnt_q <= '0;
            kind_q <= 2'd0;
            bit_q <= 1'b0;
            smp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            case (st_q)
                SL_IDLE: begin
                    cnt_q <= '0;
                    if (start_i) begin
                        kind_q <= kind_i;
                        bit_q <= bit_i;
                        st_q <= SL_LOW;
                    end
                end
                SL_LOW: begin
                    if (cnt_q == low_len - 1'b1) begin
                        // High phase is timed from the release
                        cnt_q <= '0;
                        st_q <= SL_HIGH;
                    end
                end
                SL_HIGH: begin
                    // Read sampled from slot start, presence after release
                    if (kind_q[1] && cnt_q == smp_at) begin
                        smp_q <= ~line_i;
                    end else if (!kind_q[1] &&
                        cnt_q + low_len == smp_at) begin
                        smp_q <= line_i;
                    end
                    if (done_o) begin
                        st_q <= SL_IDLE;
                    end
                end
                default: st_q <= SL_IDLE;
            endcase
        end
    end

    // Reset pulse holds the line low for at least eight cycles
    a_reset_low_len: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(line_oe_o) && kind_q == 2'd2 |-> line_oe_o [*8])
        else $error("reset pulse too short");

endmodule

// ==== stm_dev_model.sv ====
// Behavioural thermometer device hanging on the single data line
module stm_dev_model #(
    parameter logic [63:0] ROM_ID = 64'h3c00_0012_3456_785a, // Arbitrary
    parameter logic [7:0] TEMP_LSB = 8'h32 // Measured temperature byte
) (
    input wire logic line_i, // Resolved line level
    output logic pull_o // Pulls the line low while high
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int S_ROM = 0;
    localparam int S_MATCH = 1;
    localparam int S_MEM = 2;
    localparam int S_WR = 3;
    localparam int S_TX = 4;
    localparam int S_SRCH = 5;
    localparam int S_IDLE = 6;
    logic [7:0][7:0] pad; // Scratchpad bytes 0 to 7
    logic [7:0] nv_up, nv_lo; // Stored trigger bytes
    logic [71:0] txv; // Bits to send, first bit at index 0
    logic [7:0] sh; // Receive shifter
    logic alarm, prs, b, tx;
    int st, cnt, ti, si, sp, mi;
    realtime tf; // Time of the last falling edge

    // Reflected CRC over eight bytes, zero start
    function automatic logic [7:0] crc8(input logic [63:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 64; i++) begin
            c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8c : 8'h00);
        end
        return c;
    endfunction

    // Power-up state with triggers recalled
    initial begin
        pull_o = 1'b0;
        prs = 1'b0;
        st = S_IDLE;
        {cnt, ti, si, sp, mi} = '0;
        alarm = 1'b0;
        tf = 0.0;
        nv_up = 8'h46;
        nv_lo = 8'h0a;
        pad = {8'h14, 8'h0c, 8'hff, 8'hff, nv_lo, nv_up, 8'h00,
            TEMP_LSB};
    end

    // Acts on a complete received byte
    task handle_byte;
        if (st == S_ROM) begin
            case (sh)
                stm_pkg::CMD_SKIP: st = S_MEM;
                stm_pkg::CMD_MATCH: st = S_MATCH;
                stm_pkg::CMD_SEARCH: st = S_SRCH;
                stm_pkg::CMD_ALARM_SEARCH:
                    st = alarm ? S_SRCH : S_IDLE;
                stm_pkg::CMD_READ_ID: begin
                    txv = {8'h00, ROM_ID};
                    st = S_TX;
                end
                default: st = S_IDLE;
            endcase
            mi = 0;
            ti = 0;
        end else if (st == S_MEM) begin
            st = S_IDLE;
            case (sh)
                stm_pkg::CMD_WRITE_PAD: {st, mi} = {S_WR, 2};
                stm_pkg::CMD_READ_PAD: begin
                    txv = {crc8(pad), pad};
                    st = S_TX;
                end
                stm_pkg::CMD_COPY: {nv_up, nv_lo} = {pad[2], pad[3]};
                stm_pkg::CMD_CONVERT: alarm = $signed(pad[0]) > $signed(nv_up)
                    || $signed(pad[0]) < $signed(nv_lo);
                stm_pkg::CMD_RECALL:
                    {pad[2], pad[3]} = {nv_up, nv_lo};
                default: st = S_IDLE;
            endcase
        end else if (st == S_WR) begin
            pad[mi] = sh;
            mi++;
            if (mi == 4) st = S_IDLE;
        end
    endtask

    // Slot: send by holding low, or sample after the internal delay
    always @(negedge line_i) begin
        if (!prs) begin
            tf = $realtime;
            tx = (st == S_TX) || (st == S_SRCH && sp < 2);
            b = (st == S_TX) ? (ti < 72 ? txv[ti] : 1'b1)
                : ROM_ID[si] ^ (sp == 1);
            if (tx && !b) pull_o = 1'b1;
            #30us;
            pull_o = 1'b0;
            if (tx && st == S_TX) ti++;
            else if (tx) sp++;
            else if (st == S_MATCH) begin
                if (line_i !== ROM_ID[mi]) st = S_IDLE;
                else if (mi == 63) st = S_MEM;
                else mi++;
            end else if (st == S_SRCH) begin
                if (line_i !== ROM_ID[si]) st = S_IDLE;
                else {si, sp} = {si + 1, 0};
                if (si == 64) st = S_MEM;
            end else begin
                sh = {line_i, sh[7:1]};
                cnt++;
                if (cnt == 8) begin
                    cnt = 0;
                    handle_byte();
                end
            end
        end
    end

    // Long low means reset; after a full pulse, answer with presence
    always @(posedge line_i) begin
        if (!prs && $realtime - tf > 120000.0) begin
            {st, cnt, si, sp} = {S_ROM, 0, 0, 0};
            if ($realtime - tf >= 480000.0) begin
                prs = 1'b1;
                #30us pull_o = 1'b1;
                #120us pull_o = 1'b0;
                #1us prs = 1'b0;
            end
        end
    end
endmodule

// ==== stm_master_test.sv ====
// Self-checking bench for the line master against a device model
module stm_master_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] ROM_ID = 64'h3c00_0012_3456_785a; // Arbitrary
    localparam logic [7:0] TEMP_LSB = 8'h32; // Device temperature byte
    logic clk_i, rst_b_i, req_valid_i, req_ready_o, rsp_valid_o;
    stm_pkg::stm_req_type req_i;
    stm_pkg::stm_rsp_type rsp_o;
    logic [7:0] crc_o, cur_ex;
    logic line_o, line_oe_o, pullup_o, dev_pull;
    wire logic line; // Resolved data line
    int n_mismatch, tests_run;
    logic [31:0] seed; // Xorshift state
    stm_pkg::stm_op_type op_q[$], cur_op; // Expected answers, oldest first
    logic [7:0] ex_q[$];

    // Open-drain line, resistor pulls high when nobody drives low
    assign line = ((line_oe_o && !line_o) || dev_pull) ? 1'b0 : 1'b1;

    stm_master uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .crc_o(crc_o),
        .line_o(line_o), .line_oe_o(line_oe_o), .line_i(line),
        .pullup_o(pullup_o));
    stm_dev_model #(.ROM_ID(ROM_ID), .TEMP_LSB(TEMP_LSB)) dev (
        .line_i(line), .pull_o(dev_pull));

    // Clock of 50 ns
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Reflected CRC of one byte from a zero start
    function automatic logic [7:0] crc_byte(input logic [7:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ v[i]) ? stm_pkg::CRC_POLY_REFL : 8'h00);
        end
        return c;
    endfunction

    // Compares one value and counts it
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Offers one request, holds it until taken, notes the answer of all but pullup requests
    task send(input stm_pkg::stm_op_type op, input logic [7:0] d,
              input logic [7:0] ex);
        @(posedge clk_i);
        seed = xorshift(seed);
        req_valid_i <= 1'b1;
        req_i <= '{op: op, data: (op == stm_pkg::STM_OP_WRITE_BYTE) ? d
            : seed[15:8], dir_bit: seed[0]};
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        if (op <= stm_pkg::STM_OP_SEARCH_BIT) begin
            op_q.push_back(op);
            // Search answers also echo the random direction bit
            ex_q.push_back((op == stm_pkg::STM_OP_SEARCH_BIT) ?
                ex | {5'h0, seed[0], 2'b00} : ex);
        end
    endtask

    // Takes the oldest note whenever an answer appears
    always @(posedge clk_i) begin
        if (rst_b_i === 1'b1 && rsp_valid_o === 1'b1) begin
            if (op_q.size() == 0) begin
                check(8'h01, 8'h00);
            end else begin
                cur_op = op_q.pop_front();
                cur_ex = ex_q.pop_front();
                case (cur_op)
                    stm_pkg::STM_OP_RESET:
                        check({7'h0, rsp_o.presence}, 8'h01);
                    stm_pkg::STM_OP_READ_BYTE: begin
                        check(rsp_o.data, cur_ex);
                        check(crc_o, crc_byte(cur_ex));
                    end
                    stm_pkg::STM_OP_SEARCH_BIT: check({5'h0, rsp_o.dir_taken,
                        rsp_o.id_bit, rsp_o.cmp_bit}, cur_ex);
                    default: ;
                endcase
            end
        end
    end

    // Watchdog
    initial begin
        repeat (130000) @(posedge clk_i);
        n_mismatch++;
        close_out();
    end

    // Main sequence
    initial begin
        {rst_b_i, req_valid_i} = 2'b00;
        req_i = '0;
        seed = 32'h1;
        {n_mismatch, tests_run} = '0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        send(stm_pkg::STM_OP_RESET, 8'h00, 8'h00);
        send(stm_pkg::STM_OP_WRITE_BYTE, stm_pkg::CMD_SKIP, 8'h00);
        send(stm_pkg::STM_OP_WRITE_BYTE, stm_pkg::CMD_READ_PAD, 8'h00);
        send(stm_pkg::STM_OP_READ_BYTE, 8'h00, TEMP_LSB);
        send(stm_pkg::STM_OP_RESET, 8'h00, 8'h00);
        send(stm_pkg::STM_OP_WRITE_BYTE, stm_pkg::CMD_SEARCH, 8'h00);
        send(stm_pkg::STM_OP_SEARCH_BIT, 8'h00,
            {6'h0, ROM_ID[0], ~ROM_ID[0]});
        send(stm_pkg::STM_OP_PULLUP_COPY, 8'h00, 8'h00);
        for (int i = 0; i < 2000 && pullup_o !== 1'b1; i++) @(posedge clk_i);
        repeat (200) @(posedge clk_i);
        check({6'h0, line, pullup_o}, 8'h03);
        check({7'h0, op_q.size() == 0}, 8'h01);
        rst_b_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check({6'h0, line, pullup_o}, 8'h02);
        // Conversion pullup drives high, then a reset cuts it short
        send(stm_pkg::STM_OP_PULLUP_CONV, 8'h00, 8'h00);
        repeat (3) @(posedge clk_i);
        check({6'h0, line, pullup_o}, 8'h03);
        rst_b_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check({6'h0, line, pullup_o}, 8'h02);
        close_out();
    end
endmodule
